/* bcw_pkg.sv */
// package for the boot configuration word decoder
package bcw_pkg;

  // register byte offsets
  localparam logic [7:0] BCW_OFS_WORD0   = 8'h00;
  localparam logic [7:0] BCW_OFS_RTCFG   = 8'h04;
  localparam logic [7:0] BCW_OFS_BOUND   = 8'h08;
  localparam logic [7:0] BCW_OFS_STATUS  = 8'h0c;

  // field positions in boot_config_word_0
  localparam int BCW_PWP_LSB  = 10;
  localparam int BCW_PWP_MSB  = 18;
  localparam int BCW_RSV_LSB  = 5;
  localparam int BCW_RSV_MSB  = 9;
  localparam int BCW_SEL_LSB  = 3;
  localparam int BCW_SEL_MSB  = 4;
  localparam int BCW_SCAN_BIT = 2;
  localparam int BCW_DBG_MSB  = 1;
  localparam int BCW_DBG_LSB  = 0;

  // runtime_config_control field position
  localparam int BCW_RT_SCAN_BIT = 3;

  // reset word, protection-off code, forced debug field and unmapped read value
  localparam logic [31:0] BCW_WORD_RST  = 32'hffff_ffff;
  localparam logic [8:0]  BCW_PWP_OFF   = 9'h1ff;
  localparam logic [1:0]  BCW_DBG_FORCE = 2'h3;
  localparam logic [31:0] BCW_RD_UNMAP  = 32'h0000_0000;

  // page size as a shift, 1 KB pages
  localparam int BCW_PAGE_SHIFT = 10;

  typedef enum logic [3:0] {
    BCW_PAIR_ONE   = 4'h1,
    BCW_PAIR_TWO   = 4'h2,
    BCW_PAIR_THREE = 4'h4,
    BCW_PAIR_FOUR  = 4'h8
  } bcw_pair_t;

  typedef enum logic [2:0] {
    BCW_ST_RESET   = 3'h1,
    BCW_ST_CAPTURE = 3'h2,
    BCW_ST_HOLD    = 3'h4
  } bcw_state_t;

  typedef struct packed {
    logic        wp_active;
    logic [19:0] wp_boundary;
    bcw_pair_t   pair;
    logic        scan_en;
    logic        dbg_en;
  } bcw_decoded_t;

endpackage

/* bcw_decoder.sv */
// boot configuration word decoder with wishbone register access
`timescale 1ns/100ps
// Summary of operation
// - word bits 18..10 set the flash write-protect boundary
// - all ones disables protection; one below protects below 0x0400
// - each decrement raises the boundary by one 1 KB page
// - code 011111111 protects below 0x40000
// - all zeros protects every protectable address
// - bits 8 and 7 only count on 256 KB flash variants
// - bits 4..3 pick debug pin pair: 11 one, 10 two, 01 three, 00 four
// - bit 2 high enables the boundary-scan port
// - bit 2 is copied into runtime_config_control scan enable bit
// - debugger field upper bit one disables, zero enables
// - code protection forces debugger field to 11
module bcw_decoder
  import bcw_pkg::*;
#(
  parameter bit HAS_256K = 1'b1
)(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [31:0] cfg_word_i,
  input  wire logic        code_protect_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wp_active_o,
  output logic      [19:0] wp_boundary_o,
  output logic      [3:0]  debug_pair_o,
  output logic             scan_port_enable_o,
  output logic             debug_enable_o,
  output logic             ready_o
);

  // pins come from outside the clock domain
  logic [31:0] word_s1;
  logic [31:0] word_s2;
  logic        prot_s1;
  logic        prot_s2;

  always_ff @(posedge clk_i)
  begin
    word_s1 <= cfg_word_i;
    word_s2 <= word_s1;
    prot_s1 <= code_protect_i;
    prot_s2 <= prot_s1;
  end

  bcw_state_t   state;
  logic [31:0]  word;
  logic         prot;
  logic         rt_scan;
  bcw_decoded_t next_dec;
  bcw_decoded_t dec;

  // one extra cycle lets the synchronisers fill before capture
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state <= BCW_ST_RESET;
    else
    begin
      unique case (state)
        BCW_ST_RESET:   state <= BCW_ST_CAPTURE;
        BCW_ST_CAPTURE: state <= BCW_ST_HOLD;
        BCW_ST_HOLD:    state <= BCW_ST_HOLD;
        default:        state <= BCW_ST_RESET;
      endcase
    end
  end

  // capture exactly once after reset release
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      word <= BCW_WORD_RST;
      prot <= 1'b1;
    end
    else if (state == BCW_ST_CAPTURE)
    begin
      word <= word_s2;
      prot <= prot_s2;
    end
  end

  logic [8:0]  pwp;
  logic [8:0]  pages;
  logic [1:0]  dbg_field;

  always_comb
  begin
    pwp = word[BCW_PWP_MSB:BCW_PWP_LSB];
    // upper bits are absent on small parts and read as ones
    if (!HAS_256K)
      pwp[8:7] = 2'h3;
    // pages protected equals the distance below all ones
    pages = BCW_PWP_OFF - pwp;
    dbg_field = word[BCW_DBG_MSB:BCW_DBG_LSB];
    if (prot)
      dbg_field = BCW_DBG_FORCE;
    next_dec.wp_active   = (pwp != BCW_PWP_OFF);
    // all zeros gives 511 pages, the whole protectable range
    next_dec.wp_boundary = {1'b0, pages, 10'h000};
    unique case (word[BCW_SEL_MSB:BCW_SEL_LSB])
      2'h3: next_dec.pair = BCW_PAIR_ONE;
      2'h2: next_dec.pair = BCW_PAIR_TWO;
      2'h1: next_dec.pair = BCW_PAIR_THREE;
      2'h0: next_dec.pair = BCW_PAIR_FOUR;
    endcase
    next_dec.scan_en = word[BCW_SCAN_BIT];
    next_dec.dbg_en  = ~dbg_field[1];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dec.wp_active   <= 1'b1;
      dec.wp_boundary <= 20'h00000;
      dec.pair        <= BCW_PAIR_ONE;
      dec.scan_en     <= 1'b0;
      dec.dbg_en      <= 1'b0;
    end
    else if (state == BCW_ST_HOLD)
      dec <= next_dec;
  end

  // ready waits for the decoded flops, so ready and the outputs fed from dec rise together; the scan output rises a cycle earlier
  logic dec_vld;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dec_vld <= 1'b0;
    else if (state == BCW_ST_HOLD)
      dec_vld <= 1'b1;
  end

  // reserved bits are not checked; a programmer leaving zeros there is ignored

  // runtime copy of the scan enable; software may later change it
  logic wr_hit;
  assign wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rt_scan <= 1'b0;
    else if (state == BCW_ST_CAPTURE)
      rt_scan <= word_s2[BCW_SCAN_BIT];
    else if (state == BCW_ST_HOLD && wr_hit && wb_adr_i == BCW_OFS_RTCFG && wb_sel_i[0])
      rt_scan <= wb_dat_i[BCW_RT_SCAN_BIT];
  end

  // outputs from flops
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wp_active_o        <= 1'b1;
      wp_boundary_o      <= 20'h00000;
      debug_pair_o       <= BCW_PAIR_ONE;
      scan_port_enable_o <= 1'b0;
      debug_enable_o     <= 1'b0;
      ready_o            <= 1'b0;
    end
    else
    begin
      wp_active_o        <= dec.wp_active;
      wp_boundary_o      <= dec.wp_active ? dec.wp_boundary : 20'h00000;
      debug_pair_o       <= dec.pair;
      scan_port_enable_o <= rt_scan;
      debug_enable_o     <= dec.dbg_en;
      ready_o            <= dec_vld;
    end
  end

  // wishbone classic slave, one registered ack per request, raised the cycle after strobe is sampled
  logic [31:0] rd_data;

  always_comb
  begin
    unique case (wb_adr_i)
      BCW_OFS_WORD0:  rd_data = word;
      BCW_OFS_RTCFG:  rd_data = {28'h0000000, rt_scan, 3'h0};
      BCW_OFS_BOUND:  rd_data = {12'h000, dec.wp_boundary};
      BCW_OFS_STATUS: rd_data = {26'h0, dec.pair, dec.dbg_en, ready_o};
      default:        rd_data = BCW_RD_UNMAP;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o) ? rd_data : 32'h0000_0000;
    end
  end

  // checks
  sequence s_held;
    state == BCW_ST_HOLD;
  endsequence

  chk_boundary_off: assert property (@(posedge clk_i) disable iff (rst_i)
    !wp_active_o |-> wp_boundary_o == 20'h00000)
    else $error("boundary set while protection off");

  chk_boundary_step: assert property (@(posedge clk_i) disable iff (rst_i)
    s_held ##1 s_held |-> dec.wp_boundary + {1'b0, pwp, 10'h000} == 20'h7fc00)
    else $error("boundary not one page per step");

  chk_pair_map: assert property (@(posedge clk_i) disable iff (rst_i)
    s_held ##1 s_held |=> debug_pair_o == (word[4:3] == 2'h3 ? 4'h1 : word[4:3] == 2'h2 ? 4'h2 :
                                           word[4:3] == 2'h1 ? 4'h4 : 4'h8))
    else $error("debug pair wrong");

  chk_dbg_force: assert property (@(posedge clk_i) disable iff (rst_i)
    (prot && state == BCW_ST_HOLD) ##1 s_held |=> !debug_enable_o)
    else $error("debugger enabled under protection");

  chk_dbg_field: assert property (@(posedge clk_i) disable iff (rst_i)
    (!prot && state == BCW_ST_HOLD) ##1 s_held |=> debug_enable_o == ~word[1])
    else $error("debugger enable wrong");

  chk_word_stable: assert property (@(posedge clk_i) disable iff (rst_i)
    s_held ##1 s_held |-> $stable(word))
    else $error("word changed after capture");

  chk_scan_copy: assert property (@(posedge clk_i) disable iff (rst_i)
    state == BCW_ST_CAPTURE |=> rt_scan == word[BCW_SCAN_BIT])
    else $error("scan enable not copied");

  chk_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

  chk_ack_reply: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged");

  chk_ack_data: assert property (@(posedge clk_i) disable iff (rst_i)
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");

  // sampled reset in the antecedent skips the release edge itself
  sequence s_boot_walk;
    state == BCW_ST_CAPTURE ##1 state == BCW_ST_HOLD;
  endsequence

  chk_boot_walk: assert property (@(posedge clk_i) disable iff (rst_i)
    state == BCW_ST_RESET && !rst_i |=> s_boot_walk)
    else $error("capture sequence broken");

  chk_ready_align: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(ready_o) |-> wp_active_o == dec.wp_active && debug_enable_o == dec.dbg_en && debug_pair_o == dec.pair)
    else $error("ready before decoded outputs");

  chk_ready_stays: assert property (@(posedge clk_i) disable iff (rst_i)
    ready_o |=> ready_o)
    else $error("ready dropped without reset");

  chk_prot_stable: assert property (@(posedge clk_i) disable iff (rst_i)
    s_held ##1 s_held |-> $stable(prot))
    else $error("protect flag changed after capture");

  chk_wp_active: assert property (@(posedge clk_i) disable iff (rst_i)
    s_held ##1 s_held |-> dec.wp_active == (pwp != 9'h1ff))
    else $error("protection enable wrong");

  chk_wp_first: assert property (@(posedge clk_i) disable iff (rst_i)
    s_held ##1 s_held |-> pwp != 9'h1fe || dec.wp_boundary == 20'h00400)
    else $error("first page boundary wrong");

  chk_wp_eight: assert property (@(posedge clk_i) disable iff (rst_i)
    s_held ##1 s_held |-> pwp != 9'h1f7 || dec.wp_boundary == 20'h02000)
    else $error("8 KB boundary wrong");

  chk_wp_top: assert property (@(posedge clk_i) disable iff (rst_i)
    s_held ##1 s_held |-> pwp != 9'h0ff || dec.wp_boundary == 20'h40000)
    else $error("256 KB boundary wrong");

  chk_wp_all: assert property (@(posedge clk_i) disable iff (rst_i)
    s_held ##1 s_held |-> pwp != 9'h000 || dec.wp_boundary == 20'h7fc00)
    else $error("full protection boundary wrong");

  chk_pair_onehot: assert property (@(posedge clk_i) disable iff (rst_i)
    $onehot(debug_pair_o))
    else $error("debug pair not one-hot");

  chk_scan_field: assert property (@(posedge clk_i) disable iff (rst_i)
    s_held ##1 s_held |-> dec.scan_en == word[2])
    else $error("scan enable field wrong");

  chk_scan_out: assert property (@(posedge clk_i) disable iff (rst_i)
    s_held |=> scan_port_enable_o == $past(rt_scan))
    else $error("scan output not runtime bit");

endmodule

/* test_bcw_decoder.sv */
// testbench for the boot configuration word decoder
`timescale 1ns/100ps
module test_bcw_decoder;
  import bcw_pkg::*;
  logic        clk_i, rst_i, code_protect_i, wb_cyc_i, wb_stb_i, wb_we_i;
  logic        wb_ack_o, wp_active_o, scan_port_enable_o, debug_enable_o, ready_o;
  logic [31:0] cfg_word_i, wb_dat_i, wb_dat_o, rd, w;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i, debug_pair_o;
  logic [19:0] wp_boundary_o;
  int          failures, compares;

  bcw_decoder DUT (.clk_i(clk_i), .rst_i(rst_i), .cfg_word_i(cfg_word_i),
    .code_protect_i(code_protect_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wp_active_o(wp_active_o),
    .wp_boundary_o(wp_boundary_o), .debug_pair_o(debug_pair_o),
    .scan_port_enable_o(scan_port_enable_o), .debug_enable_o(debug_enable_o),
    .ready_o(ready_o));

  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task summarize;
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // classic single cycle, held until ack is sampled
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (n == 20)
    begin
      failures++;
      summarize;
    end
  endtask

  // word must sit still across release: the inputs pass two sync flops
  task boot(input logic [8:0] p, input logic [1:0] s, input logic sc, input logic [1:0] dg, input logic cp);
    int n;
    w = {13'h1fff, p, 5'h1f, s, sc, dg};
    @(posedge clk_i);
    rst_i <= 1'b1;
    cfg_word_i <= w;
    code_protect_i <= cp;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    n = 0;
    while (ready_o !== 1'b1 && n < 20)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n == 20)
    begin
      failures++;
      summarize;
    end
  endtask

  // expectations come from the captured word w and protect flag cp
  task check(input logic cp);
    logic [8:0] p;
    p = w[18:10];
    chk("boundary", {23'h0, 9'h1ff - p} << 10, {12'h0, wp_boundary_o});
    chk("active", {31'h0, p != 9'h1ff}, {31'h0, wp_active_o});
    chk("pair", 32'h1 << (3 - w[4:3]), {28'h0, debug_pair_o});
    chk("scan", {31'h0, w[2]}, {31'h0, scan_port_enable_o});
    chk("debug", {31'h0, !w[1] && !cp}, {31'h0, debug_enable_o});
    wb(1'b0, BCW_OFS_RTCFG, 32'h0);
    chk("rtcfg", {31'h0, w[2]}, {31'h0, rd[BCW_RT_SCAN_BIT]});
    wb(1'b0, BCW_OFS_WORD0, 32'h0);
    chk("word", w, rd);
  endtask

  task sc_codes;
    boot(9'h1fe, 2'b11, 1'b1, 2'b00, 1'b0);
    check(1'b0);
    boot(9'h1f7, 2'b10, 1'b0, 2'b10, 1'b0);
    check(1'b0);
    boot(9'h0ff, 2'b01, 1'b1, 2'b01, 1'b1);
    check(1'b1);
    boot(9'h000, 2'b00, 1'b0, 2'b11, 1'b0);
    check(1'b0);
    boot(9'h1ff, 2'b11, 1'b1, 2'b00, 1'b1);
    check(1'b1);
  endtask

  // late word changes must not leak through
  task sc_hold;
    boot(9'h1f0, 2'b10, 1'b1, 2'b00, 1'b0);
    cfg_word_i <= 32'h0000_0000;
    code_protect_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    check(1'b0);
  endtask

  task sc_bus;
    boot(9'h1fb, 2'b01, 1'b1, 2'b01, 1'b0);
    wb(1'b1, BCW_OFS_WORD0, 32'h0);
    wb(1'b0, BCW_OFS_WORD0, 32'h0);
    chk("ro_word", w, rd);
    wb(1'b0, BCW_OFS_BOUND, 32'h0);
    chk("bound_reg", 32'h0000_1000, rd);
    wb(1'b0, 8'h10, 32'h0);
    chk("unmapped", BCW_RD_UNMAP, rd);
    wb(1'b0, BCW_OFS_STATUS, 32'h0);
    chk("status", 32'h0000_0013, rd);
    wb(1'b1, BCW_OFS_RTCFG, 32'h0);
    wb(1'b0, BCW_OFS_RTCFG, 32'h0);
    chk("rt_clear", 32'h0, {31'h0, rd[BCW_RT_SCAN_BIT]});
    chk("scan_rt", 32'h0, {31'h0, scan_port_enable_o});
  endtask

  initial
  begin
    failures = 0;
    compares = 0;
    rst_i = 1'b1;
    cfg_word_i = 32'hffff_ffff;
    code_protect_i = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'hf;
    sc_codes;
    sc_hold;
    sc_bus;
    summarize;
  end
endmodule
